//--- design/flash_seq_map.vh
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH

// Opcodes
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_QUAD_PAGE 8'h32
`define OP_SECTOR_WIPE 8'h20
`define OP_BLOCK32_WIPE 8'h52
`define OP_BLOCK64_WIPE 8'hd8
`define OP_CHIP_WIPE_A 8'h60
`define OP_CHIP_WIPE_B 8'hc7
`define OP_DEEP_SLEEP 8'hb9
`define OP_WAKE_ID 8'hab
`define OP_RESET_EN 8'h66
`define OP_RESET 8'h99

// Frame geometry
`define OPC_LAST_BIT 5'h07
`define ADDR_LAST_BIT 5'h17
`define PAGE_BYTES 9'h100

// Erase kinds and address masks
`define KIND_SECTOR 2'h0
`define KIND_BLOCK32 2'h1
`define KIND_BLOCK64 2'h2
`define KIND_CHIP 2'h3
`define MASK_SECTOR 24'h000fff
`define MASK_BLOCK32 24'h007fff
`define MASK_BLOCK64 24'h00ffff
`define MASK_CHIP 24'hffffff

// Protection geometry
`define PROT_UNIT_SMALL 25'h0001000
`define PROT_UNIT_LARGE 25'h0010000
`define ARRAY_TOP 25'h1000000

// Timing
`define CLK_PERIOD_NS 100
`define PROG_TIME_US 700
`define SECTOR_TIME_MS 100
`define BLOCK32_TIME_MS 300
`define BLOCK64_TIME_MS 500
`define CHIP_TIME_MS 60000
`define SLEEP_ENTRY_US 3

`endif

//--- design/flash_seq.v
`timescale 1ns/1ps
`include "flash_seq_map.vh"

module flash_seq #(
    parameter PROG_CYCLES = `PROG_TIME_US * 1000 / `CLK_PERIOD_NS,
    parameter SECTOR_CYCLES = `SECTOR_TIME_MS * (1000000 / `CLK_PERIOD_NS),
    parameter BLOCK32_CYCLES = `BLOCK32_TIME_MS * (1000000 / `CLK_PERIOD_NS),
    parameter BLOCK64_CYCLES = `BLOCK64_TIME_MS * (1000000 / `CLK_PERIOD_NS),
    parameter CHIP_CYCLES = `CHIP_TIME_MS * (1000000 / `CLK_PERIOD_NS),
    parameter SLEEP_CYCLES = `SLEEP_ENTRY_US * 1000 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire CLK,
    input wire RST_B,
    // Serial link pins
    input wire CS_B,
    input wire SCLK,
    input wire QUAD_LANE_0,
    input wire QUAD_LANE_1,
    input wire QUAD_LANE_2,
    input wire QUAD_LANE_3,
    // Configuration bits
    input wire QUAD_LANE_ENABLE,
    input wire [4:0] PROTECT_RANGE,
    input wire PROTECT_INVERT_BIT,
    // Status
    output wire BUSY_FLAG,
    output wire WRITE_LATCH_FLAG,
    output wire DEEP_SLEEP,
    // Array program port
    output wire ARRAY_WE,
    output wire [23:0] ARRAY_ADDR,
    output wire [7:0] ARRAY_DATA,
    // Array erase port
    output wire ERASE_PULSE,
    output wire [1:0] ERASE_KIND,
    output wire [23:0] ERASE_ADDR
);

    localparam F_CMD = 5'h01;
    localparam F_ADDR = 5'h02;
    localparam F_DATA = 5'h04;
    localparam F_FULL = 5'h08;
    localparam F_IGN = 5'h10;

    localparam C_IDLE = 5'h01;
    localparam C_PROG = 5'h02;
    localparam C_ERASE = 5'h04;
    localparam C_ENTER = 5'h08;
    localparam C_SLEEP = 5'h10;

    // Pin bit positions inside the synchroniser vector
    localparam P_CS = 5;
    localparam P_SCK = 4;

    function prot_hit;
        input [23:0] a;
        input [4:0] bp;
        input inv;
        reg [24:0] len;
        reg hit;
        begin
            len = 25'h0;
            hit = 1'b0;
            if (bp[2:0] != 3'h0) begin
                len = (bp[4] ? `PROT_UNIT_SMALL : `PROT_UNIT_LARGE) << (bp[2:0] - 3'h1);
                // Bit 3 selects a bottom-anchored range, else top-anchored
                hit = bp[3] ? ({1'b0, a} < len) : ({1'b0, a} >= (`ARRAY_TOP - len));
            end
            prot_hit = hit ^ inv;
        end
    endfunction

    // Ranges are contiguous from one end, so checking both ends catches any overlap
    function range_hit;
        input [23:0] base;
        input [23:0] mask;
        input [4:0] bp;
        input inv;
        begin
            range_hit = prot_hit(base & ~mask, bp, inv) | prot_hit(base | mask, bp, inv);
        end
    endfunction

    function [4:0] decode_next;
        input [7:0] op;
        input asleep;
        input busy;
        input qe;
        begin
            if (asleep) begin
                decode_next = (op == `OP_WAKE_ID || op == `OP_RESET_EN || op == `OP_RESET) ?
                    F_FULL : F_IGN;
            end else if (busy) begin
                decode_next = F_IGN;
            end else begin
                case (op)
                    `OP_QUAD_PAGE: decode_next = qe ? F_ADDR : F_IGN;
                    `OP_SECTOR_WIPE, `OP_BLOCK32_WIPE, `OP_BLOCK64_WIPE: decode_next = F_ADDR;
                    `OP_WR_ENABLE, `OP_WR_DISABLE, `OP_CHIP_WIPE_A, `OP_CHIP_WIPE_B,
                    `OP_DEEP_SLEEP, `OP_WAKE_ID, `OP_RESET_EN, `OP_RESET: decode_next = F_FULL;
                    default: decode_next = F_IGN;
                endcase
            end
        end
    endfunction

    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n = rst_s2_r;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // Three-stage pin capture; a level is accepted once stages two and three agree
    wire [5:0] pins = {CS_B, SCLK, QUAD_LANE_3, QUAD_LANE_2, QUAD_LANE_1, QUAD_LANE_0};
    reg [5:0] s1_r;
    reg [5:0] s2_r;
    reg [5:0] s3_r;
    reg [5:0] flt_r;
    reg [5:0] prev_r;
    wire [5:0] flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 6'h3f;
            s2_r <= 6'h3f;
            s3_r <= 6'h3f;
            flt_r <= 6'h3f;
            prev_r <= 6'h3f;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            prev_r <= flt_r;
        end
    end

    wire sck_rise = flt_r[P_SCK] & ~prev_r[P_SCK] & ~flt_r[P_CS];
    wire cs_fall = ~flt_r[P_CS] & prev_r[P_CS];
    wire cs_rise = flt_r[P_CS] & ~prev_r[P_CS];
    wire si = flt_r[0];
    wire [3:0] lanes = flt_r[3:0];

    reg [4:0] fst_r;
    reg [4:0] cst_r;
    reg [4:0] bcnt_r;
    reg [23:0] shift_r;
    reg [7:0] op_r;
    reg [23:0] addr_r;
    reg [7:0] wptr_r;
    reg [3:0] nib_r;
    reg nib_hi_r;
    reg any_byte_r;
    reg latch_r;
    reg busy_r;
    reg deep_r;
    reg rst_en_r;
    reg [31:0] cnt_r;
    reg [8:0] idx_r;
    reg [255:0] valid_r;
    reg [7:0] buf_r [0:255];
    reg we_r;
    reg [23:0] waddr_r;
    reg [7:0] wdata_r;
    reg erase_r;
    reg [1:0] kind_r;
    reg [23:0] eaddr_r;

    wire asleep = (cst_r == C_ENTER) || (cst_r == C_SLEEP);
    wire byte_done = sck_rise && (fst_r == F_DATA) && nib_hi_r;
    wire opc_done = sck_rise && (fst_r == F_CMD) && (bcnt_r == `OPC_LAST_BIT);
    wire [7:0] opc_now = {shift_r[6:0], si};

    // Frame decoder
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            fst_r <= F_CMD;
            bcnt_r <= 5'h0;
            shift_r <= 24'h0;
            op_r <= 8'h0;
            addr_r <= 24'h0;
            wptr_r <= 8'h0;
            nib_r <= 4'h0;
            nib_hi_r <= 1'b0;
            any_byte_r <= 1'b0;
        end else if (cs_fall) begin
            fst_r <= F_CMD;
            bcnt_r <= 5'h0;
            nib_hi_r <= 1'b0;
            any_byte_r <= 1'b0;
        end else if (sck_rise) begin
            case (fst_r)
                F_CMD: begin
                    shift_r <= {shift_r[22:0], si};
                    if (bcnt_r == `OPC_LAST_BIT) begin
                        op_r <= opc_now;
                        fst_r <= decode_next(opc_now, asleep, busy_r, QUAD_LANE_ENABLE);
                        bcnt_r <= 5'h0;
                    end else begin
                        bcnt_r <= bcnt_r + 5'h1;
                    end
                end
                F_ADDR: begin
                    shift_r <= {shift_r[22:0], si};
                    if (bcnt_r == `ADDR_LAST_BIT) begin
                        addr_r <= {shift_r[22:0], si};
                        wptr_r <= shift_r[6:0] == 7'h0 && si == 1'b0 ? 8'h0 : {shift_r[6:0], si};
                        fst_r <= (op_r == `OP_QUAD_PAGE) ? F_DATA : F_FULL;
                        bcnt_r <= 5'h0;
                    end else begin
                        bcnt_r <= bcnt_r + 5'h1;
                    end
                end
                F_DATA: begin
                    if (nib_hi_r) begin
                        // Low byte of the pointer wraps inside the page
                        wptr_r <= wptr_r + 8'h1;
                        any_byte_r <= 1'b1;
                        nib_hi_r <= 1'b0;
                    end else begin
                        nib_r <= lanes;
                        nib_hi_r <= 1'b1;
                    end
                end
                F_FULL: fst_r <= F_IGN;
                F_IGN: fst_r <= F_IGN;
                default: fst_r <= F_IGN;
            endcase
        end
    end

    // Page buffer: later bytes at the same offset overwrite earlier ones
    always @(posedge CLK) begin
        if (byte_done) begin
            buf_r[wptr_r] <= {nib_r, lanes};
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= 256'h0;
        end else if (opc_done && opc_now == `OP_QUAD_PAGE && !busy_r && !asleep) begin
            // A refused 32H during a running program must not wipe the offsets being streamed
            valid_r <= 256'h0;
        end else if (byte_done) begin
            valid_r[wptr_r] <= 1'b1;
        end
    end

    wire frame_full = (fst_r == F_FULL);
    wire prog_ok = (fst_r == F_DATA) && !nib_hi_r && any_byte_r;
    wire exec = cs_rise && ((cst_r == C_IDLE) || (cst_r == C_SLEEP));
    wire chip_open = (PROTECT_RANGE[2:0] == 3'h0 && !PROTECT_INVERT_BIT) ||
        (PROTECT_RANGE[2:0] == 3'h7 && PROTECT_INVERT_BIT);
    wire [23:0] page_mask = 24'h0000ff;
    reg [23:0] emask;
    reg [1:0] ekind;
    reg [31:0] ecycles;

    always @* begin
        emask = `MASK_SECTOR;
        ekind = `KIND_SECTOR;
        ecycles = SECTOR_CYCLES;
        case (op_r)
            `OP_BLOCK32_WIPE: begin
                emask = `MASK_BLOCK32;
                ekind = `KIND_BLOCK32;
                ecycles = BLOCK32_CYCLES;
            end
            `OP_BLOCK64_WIPE: begin
                emask = `MASK_BLOCK64;
                ekind = `KIND_BLOCK64;
                ecycles = BLOCK64_CYCLES;
            end
            `OP_CHIP_WIPE_A, `OP_CHIP_WIPE_B: begin
                emask = `MASK_CHIP;
                ekind = `KIND_CHIP;
                ecycles = CHIP_CYCLES;
            end
            default: begin
                emask = `MASK_SECTOR;
                ekind = `KIND_SECTOR;
                ecycles = SECTOR_CYCLES;
            end
        endcase
    end

    wire is_erase = (op_r == `OP_SECTOR_WIPE) || (op_r == `OP_BLOCK32_WIPE) ||
        (op_r == `OP_BLOCK64_WIPE);
    wire is_chip = (op_r == `OP_CHIP_WIPE_A) || (op_r == `OP_CHIP_WIPE_B);

    // Self-timed cycle engine; power-up lands in standby
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cst_r <= C_IDLE;
            latch_r <= 1'b0;
            busy_r <= 1'b0;
            deep_r <= 1'b0;
            rst_en_r <= 1'b0;
            cnt_r <= 32'h0;
            idx_r <= 9'h0;
            we_r <= 1'b0;
            waddr_r <= 24'h0;
            wdata_r <= 8'h0;
            erase_r <= 1'b0;
            kind_r <= 2'h0;
            eaddr_r <= 24'h0;
        end else begin
            we_r <= 1'b0;
            erase_r <= 1'b0;
            case (cst_r)
                C_IDLE, C_SLEEP: begin
                    if (exec && frame_full) begin
                        rst_en_r <= (op_r == `OP_RESET_EN);
                        if (op_r == `OP_WR_ENABLE) begin
                            latch_r <= 1'b1;
                        end else if (op_r == `OP_WR_DISABLE) begin
                            latch_r <= 1'b0;
                        end else if (op_r == `OP_WAKE_ID) begin
                            cst_r <= C_IDLE;
                            deep_r <= 1'b0;
                        end else if (op_r == `OP_RESET && rst_en_r) begin
                            cst_r <= C_IDLE;
                            deep_r <= 1'b0;
                            latch_r <= 1'b0;
                        end else if (op_r == `OP_DEEP_SLEEP && cst_r == C_IDLE) begin
                            cst_r <= C_ENTER;
                            cnt_r <= SLEEP_CYCLES;
                        end else if ((is_erase && !range_hit(addr_r, emask, PROTECT_RANGE,
                            PROTECT_INVERT_BIT)) || (is_chip && chip_open)) begin
                            if (latch_r) begin
                                cst_r <= C_ERASE;
                                busy_r <= 1'b1;
                                latch_r <= 1'b0;
                                cnt_r <= ecycles;
                                erase_r <= 1'b1;
                                kind_r <= ekind;
                                eaddr_r <= addr_r & ~emask;
                            end
                        end
                    end else if (exec && prog_ok && latch_r && op_r == `OP_QUAD_PAGE) begin
                        rst_en_r <= 1'b0;
                        if (!range_hit(addr_r, page_mask, PROTECT_RANGE,
                            PROTECT_INVERT_BIT)) begin
                            cst_r <= C_PROG;
                            busy_r <= 1'b1;
                            latch_r <= 1'b0;
                            cnt_r <= PROG_CYCLES;
                            idx_r <= 9'h0;
                        end
                    end
                end
                C_PROG: begin
                    // Stream only captured offsets; untouched page bytes keep their contents
                    if (idx_r < `PAGE_BYTES) begin
                        idx_r <= idx_r + 9'h1;
                        we_r <= valid_r[idx_r[7:0]];
                        waddr_r <= {addr_r[23:8], idx_r[7:0]};
                        wdata_r <= buf_r[idx_r[7:0]];
                    end
                    if (cnt_r <= 32'h1) begin
                        cst_r <= C_IDLE;
                        busy_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                C_ERASE: begin
                    if (cnt_r <= 32'h1) begin
                        cst_r <= C_IDLE;
                        busy_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                C_ENTER: begin
                    if (cnt_r <= 32'h1) begin
                        cst_r <= C_SLEEP;
                        deep_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                default: cst_r <= C_IDLE;
            endcase
        end
    end

    assign BUSY_FLAG = busy_r;
    assign WRITE_LATCH_FLAG = latch_r;
    assign DEEP_SLEEP = deep_r;
    assign ARRAY_WE = we_r;
    assign ARRAY_ADDR = waddr_r;
    assign ARRAY_DATA = wdata_r;
    assign ERASE_PULSE = erase_r;
    assign ERASE_KIND = kind_r;
    assign ERASE_ADDR = eaddr_r;

endmodule

//--- tb/flash_seq_checker.sv
`timescale 1ns/1ps
module flash_seq_checker #(
    parameter PROG_CYCLES = 300,
    parameter SECTOR_CYCLES = 50,
    parameter BLOCK32_CYCLES = 50,
    parameter BLOCK64_CYCLES = 50,
    parameter CHIP_CYCLES = 50
) (
    // Clock, reset and link select
    input wire CLK,
    input wire RST_B,
    input wire CS_B,
    // Configuration and status
    input wire [4:0] PROTECT_RANGE,
    input wire PROTECT_INVERT_BIT,
    input wire BUSY_FLAG,
    input wire WRITE_LATCH_FLAG,
    input wire DEEP_SLEEP,
    // Array ports
    input wire ARRAY_WE,
    input wire [23:0] ARRAY_ADDR,
    input wire ERASE_PULSE,
    input wire [1:0] ERASE_KIND,
    input wire [23:0] ERASE_ADDR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    reg [31:0] busy_cnt_r;
    reg erase_r;
    wire [23:0] emask = ERASE_KIND == 2'h0 ? 24'h000fff : ERASE_KIND == 2'h1 ? 24'h007fff :
        ERASE_KIND == 2'h2 ? 24'h00ffff : 24'hffffff;
    wire [31:0] lim = !erase_r ? PROG_CYCLES : ERASE_KIND == 2'h0 ? SECTOR_CYCLES :
        ERASE_KIND == 2'h1 ? BLOCK32_CYCLES : ERASE_KIND == 2'h2 ? BLOCK64_CYCLES : CHIP_CYCLES;
    // Length of the current busy spell, and whether it came from an erase
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_cnt_r <= 32'h0;
            erase_r <= 1'b0;
        end else begin
            busy_cnt_r <= BUSY_FLAG ? busy_cnt_r + 32'h1 : 32'h0;
            erase_r <= ERASE_PULSE ? 1'b1 : (BUSY_FLAG ? erase_r : 1'b0);
        end
    end
    latch_idle_a: assert property (BUSY_FLAG |-> !WRITE_LATCH_FLAG)
        else $error("write latch set during busy cycle");
    latch_needed_a: assert property ($rose(BUSY_FLAG) |-> $past(WRITE_LATCH_FLAG))
        else $error("cycle started without write latch");
    start_on_select_a: assert property ($rose(BUSY_FLAG) |-> CS_B && $past(CS_B, 3))
        else $error("cycle started while selected");
    erase_start_a: assert property (ERASE_PULSE |-> $rose(BUSY_FLAG))
        else $error("erase pulse not at busy start");
    erase_align_a: assert property (ERASE_PULSE |-> (ERASE_ADDR & emask) == 24'h0)
        else $error("erase base not aligned to region");
    full_wipe_guard_a: assert property (ERASE_PULSE && ERASE_KIND == 2'h3 |->
        (PROTECT_RANGE[2:0] == 3'h0 && !PROTECT_INVERT_BIT) ||
        (PROTECT_RANGE[2:0] == 3'h7 && PROTECT_INVERT_BIT))
        else $error("full wipe with protected area");
    write_in_prog_a: assert property (ARRAY_WE |-> BUSY_FLAG && !erase_r)
        else $error("array write outside program cycle");
    page_wrap_a: assert property (ARRAY_WE && $past(ARRAY_WE) |->
        ARRAY_ADDR[23:8] == $past(ARRAY_ADDR[23:8]) && ARRAY_ADDR[7:0] > $past(ARRAY_ADDR[7:0]))
        else $error("array write left page or out of order");
    sleep_entry_a: assert property ($rose(DEEP_SLEEP) |-> !BUSY_FLAG && CS_B)
        else $error("sleep entered during cycle");
    sleep_quiet_a: assert property (DEEP_SLEEP |-> !BUSY_FLAG)
        else $error("cycle running while asleep");
    busy_len_a: assert property ($fell(BUSY_FLAG) |->
        busy_cnt_r + 32'h1 >= lim && busy_cnt_r <= lim + 32'h1)
        else $error("busy length differs from cycle count");
    prog_c: cover property (ARRAY_WE && $past(ARRAY_WE));
    wipe_c: cover property (ERASE_PULSE && ERASE_KIND == 2'h3);
    sleep_c: cover property ($fell(DEEP_SLEEP));
endmodule

bind flash_seq flash_seq_checker #(
    .PROG_CYCLES(PROG_CYCLES), .SECTOR_CYCLES(SECTOR_CYCLES),
    .BLOCK32_CYCLES(BLOCK32_CYCLES), .BLOCK64_CYCLES(BLOCK64_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)
) chk (
    .CLK(CLK), .RST_B(RST_B), .CS_B(CS_B), .PROTECT_RANGE(PROTECT_RANGE),
    .PROTECT_INVERT_BIT(PROTECT_INVERT_BIT), .BUSY_FLAG(BUSY_FLAG),
    .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG), .DEEP_SLEEP(DEEP_SLEEP), .ARRAY_WE(ARRAY_WE),
    .ARRAY_ADDR(ARRAY_ADDR), .ERASE_PULSE(ERASE_PULSE), .ERASE_KIND(ERASE_KIND),
    .ERASE_ADDR(ERASE_ADDR)
);

//--- tb/flash_host.sv
`timescale 1ns/1ps
module flash_host (
    // Bench clock
    input wire clk,
    // Link pins toward the device
    output reg cs_b,
    output reg sclk,
    output reg [3:0] lanes
);
    reg [3:0] nib [0:599];
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        lanes = 4'h5;
    end
    // One link clock of 800 ns: data changes only while the clock is low
    task tick(input [3:0] v);
        begin
            @(posedge clk);
            lanes <= v;
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    // Serial bits from w[31] down, then quad nibbles; clock idles low outside frames
    task xfer(input [31:0] w, input integer nb, input integer nn);
        integer i;
        begin
            @(posedge clk);
            cs_b <= 1'b0;
            for (i = 31; i >= 32 - nb; i = i - 1)
                tick({3'h0, w[i]});
            for (i = 0; i < nn; i = i + 1)
                tick(nib[i]);
            @(posedge clk);
            sclk <= 1'b0;
            repeat (3) @(posedge clk);
            cs_b <= 1'b1;
            lanes <= ~lanes;
            repeat (12) @(posedge clk);
        end
    endtask
endmodule

//--- tb/test_flash_seq.sv
`timescale 1ns/1ps
`include "flash_seq_map.vh"
module test_flash_seq;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg lane_en = 1'b0;
    reg [4:0] prot = 5'h0;
    reg inv = 1'b0;
    wire cs_b, sclk, busy, latch, sleep, we, epulse;
    wire [3:0] lanes;
    wire [23:0] waddr, eaddr;
    wire [7:0] wdata;
    wire [1:0] ekind;
    integer miscompares = 0;
    integer comparisons = 0;
    integer nwr, nerase, nbusy, seed, i, k;
    reg [7:0] got [0:255];
    reg [7:0] b [0:299];
    reg [15:0] pg;
    reg [1:0] gkind;
    reg [23:0] gaddr;
    always #50 clk = ~clk;
    flash_host lk (.clk(clk), .cs_b(cs_b), .sclk(sclk), .lanes(lanes));
    flash_seq #(
        .PROG_CYCLES(300), .SECTOR_CYCLES(50), .BLOCK32_CYCLES(50),
        .BLOCK64_CYCLES(50), .CHIP_CYCLES(50)
    ) DUT (
        .CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk),
        .QUAD_LANE_0(lanes[0]), .QUAD_LANE_1(lanes[1]),
        .QUAD_LANE_2(lanes[2]), .QUAD_LANE_3(lanes[3]),
        .QUAD_LANE_ENABLE(lane_en), .PROTECT_RANGE(prot), .PROTECT_INVERT_BIT(inv),
        .BUSY_FLAG(busy), .WRITE_LATCH_FLAG(latch), .DEEP_SLEEP(sleep),
        .ARRAY_WE(we), .ARRAY_ADDR(waddr), .ARRAY_DATA(wdata),
        .ERASE_PULSE(epulse), .ERASE_KIND(ekind), .ERASE_ADDR(eaddr)
    );
    // Stands in for the external array and counts what reaches it
    always @(posedge clk) begin
        if (we === 1'b1) begin
            got[waddr[7:0]] = wdata;
            pg = waddr[23:8];
            nwr = nwr + 1;
        end
        if (epulse === 1'b1) begin
            gkind = ekind;
            gaddr = eaddr;
            nerase = nerase + 1;
        end
        if (busy === 1'b1)
            nbusy = nbusy + 1;
    end
    function integer kept(input integer cnt);
        kept = cnt > 256 ? 256 : cnt;
    endfunction
    function [23:0] base(input [23:0] adr, input [1:0] kind);
        case (kind)
            2'h0: base = adr & ~`MASK_SECTOR;
            2'h1: base = adr & ~`MASK_BLOCK32;
            2'h2: base = adr & ~`MASK_BLOCK64;
            default: base = 24'h0;
        endcase
    endfunction
    function [7:0] op_of(input integer j);
        case (j)
            0: op_of = `OP_SECTOR_WIPE;
            1: op_of = `OP_BLOCK32_WIPE;
            2: op_of = `OP_BLOCK64_WIPE;
            3: op_of = `OP_CHIP_WIPE_A;
            default: op_of = `OP_CHIP_WIPE_B;
        endcase
    endfunction
    function [1:0] kind_of(input [7:0] op);
        case (op)
            `OP_SECTOR_WIPE: kind_of = `KIND_SECTOR;
            `OP_BLOCK32_WIPE: kind_of = `KIND_BLOCK32;
            `OP_BLOCK64_WIPE: kind_of = `KIND_BLOCK64;
            default: kind_of = `KIND_CHIP;
        endcase
    endfunction
    task check(input [31:0] seen, input [31:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task cmd(input [31:0] w, input integer nb, input integer nn, input integer wait_n);
        begin
            nwr = 0;
            nerase = 0;
            nbusy = 0;
            lk.xfer(w, nb, nn);
            repeat (wait_n) @(posedge clk);
        end
    endtask
    task prog(input [23:0] adr, input integer cnt, input integer odd, input integer run,
        input [7:0] first);
        begin
            for (k = 0; k < cnt; k = k + 1) begin
                b[k] = $urandom;
                lk.nib[2 * k] = b[k][7:4];
                lk.nib[2 * k + 1] = b[k][3:0];
            end
            cmd({first, 24'h0}, 8, 0, 4);
            cmd({`OP_QUAD_PAGE, adr}, 32, 2 * cnt - odd, 360);
            check(nwr, run ? kept(cnt) : 0);
            if (run) begin
                check(pg, adr[23:8]);
                for (k = cnt - kept(cnt); k < cnt; k = k + 1)
                    check(got[(adr[7:0] + k) % 256], b[k]);
                check(nbusy != 0, 1);
            end
            check(latch, !run && first == `OP_WR_ENABLE);
            check(busy, 0);
        end
    endtask
    task erase(input [7:0] op, input [23:0] adr, input integer nb, input integer run);
        begin
            cmd({`OP_WR_ENABLE, 24'h0}, 8, 0, 4);
            cmd({op, adr}, nb - 1, 0, 60);
            check(nerase, 0);
            cmd({op, adr}, nb, 0, 80);
            check(nerase, run);
            if (run) begin
                check(gkind, kind_of(op));
                check(gaddr, base(adr, kind_of(op)));
                check(nbusy != 0, 1);
            end
            check(busy, 0);
            check(latch, !run);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #8000000;
        miscompares = miscompares + 1;
        end_of_test;
    end
    initial begin
        seed = $urandom(97869);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        check({busy, latch, sleep}, 3'h0);
        lane_en <= 1'b1;
        prog(24'h0000fe, 300, 0, 1, `OP_WR_ENABLE);
        prog(24'h1234fd, 5, 0, 1, `OP_WR_ENABLE);
        for (i = 0; i < 3; i = i + 1)
            prog($urandom, 1 + $urandom % 300, 0, 1, `OP_WR_ENABLE);
        prog($urandom, 4, 1, 0, `OP_WR_ENABLE);
        prog($urandom, 2, 0, 0, `OP_WR_DISABLE);
        lane_en <= 1'b0;
        prog($urandom, 2, 0, 0, `OP_WR_ENABLE);
        lane_en <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
            erase(op_of(i), $urandom, i < 3 ? 32 : 8, 1);
        // Top 64 KiB guarded: only the low area may change
        prot <= 5'h01;
        prog(24'hff1234, 2, 0, 0, `OP_WR_ENABLE);
        for (i = 0; i < 4; i = i + 1)
            erase(op_of(i), 24'hff8000 + i, i < 3 ? 32 : 8, 0);
        erase(`OP_SECTOR_WIPE, 24'h001abc, 32, 1);
        prot <= 5'h07;
        inv <= 1'b1;
        erase(`OP_CHIP_WIPE_B, 24'h0, 8, 1);
        prot <= 5'h00;
        erase(`OP_CHIP_WIPE_A, 24'h0, 8, 0);
        inv <= 1'b0;
        cmd({`OP_WR_ENABLE, 24'h0}, 8, 0, 4);
        cmd({`OP_QUAD_PAGE, 24'h000200}, 32, 2, 0);
        cmd({`OP_DEEP_SLEEP, 24'h0}, 8, 0, 360);
        check(sleep, 0);
        check(nbusy != 0, 1);
        cmd({`OP_DEEP_SLEEP, 24'h0}, 9, 0, 30);
        check(sleep, 0);
        cmd({`OP_WR_ENABLE, 24'h0}, 8, 0, 4);
        cmd({`OP_DEEP_SLEEP, 24'h0}, 8, 0, 40);
        check(sleep, 1);
        cmd({`OP_WR_DISABLE, 24'h0}, 8, 0, 10);
        check(latch, 1);
        cmd({`OP_WAKE_ID, 24'h0}, 8, 0, 10);
        check(sleep, 0);
        cmd({`OP_DEEP_SLEEP, 24'h0}, 8, 0, 30);
        cmd({`OP_RESET_EN, 24'h0}, 8, 0, 10);
        check(sleep, 1);
        cmd({`OP_RESET, 24'h0}, 8, 0, 10);
        check(sleep, 0);
        check(latch, 0);
        end_of_test;
    end
endmodule
